/* hdl/cssp_port.sv */
// Clocked serial shift port: 8-bit shift register with master/slave clocking
// Functional notes
// - One 8-bit register shifts out and in
// - Two-bit field selects clock or slave
// - Master drives shift clock; slave takes it
// - Reset selects slave mode
// - Master stops after eight clocks, high
// - Slave ignores edges after eight clocks
// - Trigger write starts a transfer
// - Serial output changes on falling edge
// - Sample edge bit picks capture edge
// - Eight counted clocks end, flag, interrupt
// - Flag sets regardless of mask
// - Received byte readable as two halves
// - Bit order fixed at build time
// - Optional active-low ready in slave mode
// - Ready falls on trigger, rises first low
// - Upper half access forces ready high
// - Trigger write-only, reads zero
// - Reset sample edge is rising
`timescale 1ns/1ps
`include "cssp_params.svh"
module cssp_port #(
    parameter bit LSB_FIRST   = 1'b1,
    parameter bit READY_USED  = 1'b1
) (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // Configuration
    input  wire logic       i_clock_select_lo,
    input  wire logic       i_clock_select_hi,
    input  wire logic       i_cfg_we,
    input  wire logic       i_sample_edge_select,
    input  wire logic       i_transfer_done_mask,
    // Software strobes
    input  wire logic       i_transfer_trigger,
    input  wire logic       i_data_lo_we,
    input  wire logic       i_data_hi_we,
    input  wire logic       i_data_hi_rd,
    input  wire logic [3:0] i_wdata,
    input  wire logic       i_flag_clear,
    // Serial pins
    input  wire logic       i_serial_in_pin,
    input  wire logic       i_shift_clk_in,
    output logic            o_shift_clk_out,
    output logic            o_shift_clk_oe,
    output logic            o_serial_out_pin,
    output logic            o_slave_ready_n,
    // Status
    output logic [3:0]      o_shift_data_lower,
    output logic [3:0]      o_shift_data_upper,
    output logic [1:0]      o_clock_select,
    output logic            o_sample_edge_select,
    output logic            o_transfer_trigger,
    output logic            o_busy,
    output logic            o_transfer_done_flag,
    output logic            o_irq
);
    localparam int NB = `CSSP_BITS;

    typedef struct packed {
        cssp_pkg::cssp_state_t            st;
        logic [NB-1:0]                    sr;
        logic [`CSSP_CNT_W-1:0]           cnt;
        logic [`CSSP_DIV_W-1:0]           div;
        logic [`CSSP_CS_W-1:0]            cs;
        logic                             sample_edge_select;
        logic                             sclk;
        logic                             serial_out_pin;
        logic                             oe;
        logic                             rdy_n;
        logic                             flag;
        logic                             irq;
    } cssp_regs_t;

    cssp_regs_t r_q;
    cssp_regs_t r_d;
    logic       ext_rise;
    logic       ext_fall;
    logic       int_rise;
    logic       int_fall;
    logic       sh_rise;
    logic       sh_fall;
    logic       cap;
    logic       master;
    logic       done;
    logic [`CSSP_DIV_W-1:0] half;

    // External clock edge finder
    cssp_edge u_edge (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_level   (i_shift_clk_in),
        .o_rise    (ext_rise),
        .o_fall    (ext_fall)
    );

    // Half-period of the internal shift clock
    always_comb begin
        case (r_q.cs)
            `CSSP_CS_DIV1: half = `CSSP_DIV1_HALF;
            `CSSP_CS_DIV2: half = `CSSP_DIV2_HALF;
            default:       half = `CSSP_DIV4_HALF;
        endcase
    end

    assign master = (r_q.cs != `CSSP_CS_SLAVE);

    always_comb begin
        int_fall = 1'b0;
        int_rise = 1'b0;
        if (r_q.st == cssp_pkg::CSSP_RUN && master && r_q.div == half - `CSSP_DIV_W'(1)) begin
            int_fall = r_q.sclk;
            int_rise = ~r_q.sclk;
        end
    end

    assign sh_fall = (r_q.st == cssp_pkg::CSSP_RUN) & (master ? int_fall : ext_fall);
    assign sh_rise = (r_q.st == cssp_pkg::CSSP_RUN) & (master ? int_rise : ext_rise);
    assign cap     = r_q.sample_edge_select ? sh_fall : sh_rise;
    assign done    = sh_rise && r_q.cnt == `CSSP_CNT_W'(NB - 1);

    // Next-state logic
    always_comb begin
        r_d = r_q;
        if (i_cfg_we && r_q.st == cssp_pkg::CSSP_IDLE) begin
            r_d.cs  = {i_clock_select_hi, i_clock_select_lo};
            r_d.sample_edge_select = i_sample_edge_select;
        end
        if (i_data_lo_we) begin
            r_d.sr[3:0] = i_wdata;
        end
        if (i_data_hi_we) begin
            r_d.sr[7:4] = i_wdata;
        end
        case (r_q.st)
            cssp_pkg::CSSP_IDLE: begin
                if (i_transfer_trigger) begin
                    r_d.st  = cssp_pkg::CSSP_RUN;
                    r_d.cnt = '0;
                    r_d.div = '0;
                    r_d.sclk = 1'b1;
                    r_d.rdy_n = ~(READY_USED && !master);
                end
            end
            cssp_pkg::CSSP_RUN: begin
                if (master) begin
                    r_d.div = (r_q.div == half - `CSSP_DIV_W'(1)) ? '0 : r_q.div + `CSSP_DIV_W'(1);
                    if (int_fall || int_rise) begin
                        r_d.sclk = ~r_q.sclk;
                    end
                end
                if (sh_fall) begin
                    r_d.serial_out_pin = LSB_FIRST ? r_q.sr[0] : r_q.sr[NB-1];
                    r_d.rdy_n = 1'b1;
                end
                if (cap) begin
                    r_d.sr = LSB_FIRST ? {i_serial_in_pin, r_q.sr[NB-1:1]}
                                       : {r_q.sr[NB-2:0], i_serial_in_pin};
                end
                if (sh_rise) begin
                    r_d.cnt = r_q.cnt + `CSSP_CNT_W'(1);
                end
                if (done) begin
                    r_d.st   = cssp_pkg::CSSP_IDLE;
                    r_d.sclk = 1'b1;
                end
            end
            default: r_d.st = cssp_pkg::CSSP_IDLE;
        endcase
        if (i_data_hi_we || i_data_hi_rd) begin
            r_d.rdy_n = 1'b1;
        end
        r_d.oe = master;
        if (i_flag_clear) begin
            r_d.flag = 1'b0;
        end
        if (done) begin
            r_d.flag = 1'b1;
        end
        r_d.irq = r_d.flag & i_transfer_done_mask;
    end

    // State register
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_q       <= '0;
            r_q.st    <= cssp_pkg::CSSP_IDLE;
            r_q.cs    <= `CSSP_CS_RESET;
            r_q.sample_edge_select   <= `CSSP_SEN_RESET;
            r_q.sclk  <= 1'b1;
            r_q.serial_out_pin  <= 1'b1;
            r_q.rdy_n <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs straight from state
    assign o_shift_clk_out      = r_q.sclk;
    assign o_shift_clk_oe       = r_q.oe;
    assign o_serial_out_pin     = r_q.serial_out_pin;
    assign o_slave_ready_n      = r_q.rdy_n;
    assign o_shift_data_lower   = r_q.sr[3:0];
    assign o_shift_data_upper   = r_q.sr[7:4];
    assign o_clock_select       = r_q.cs;
    assign o_sample_edge_select = r_q.sample_edge_select;
    assign o_transfer_trigger   = 1'b0;
    assign o_busy               = (r_q.st == cssp_pkg::CSSP_RUN);
    assign o_transfer_done_flag = r_q.flag;
    assign o_irq                = r_q.irq;

    // Completion checks
    sequence last_rise_s;
        done;
    endsequence

    flag_on_done_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        last_rise_s |=> o_transfer_done_flag && !o_busy)
        else $error("flag not set after last clock");
    clk_idle_high_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !o_busy && $past(!o_busy) |-> o_shift_clk_out)
        else $error("shift clock not high while idle");
    trig_clears_cnt_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_transfer_trigger && !o_busy) |=> o_busy && r_q.cnt == '0)
        else $error("counter not cleared on trigger");
    irq_gated_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_irq |-> o_transfer_done_flag)
        else $error("irq without flag");
    upper_ready_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_data_hi_rd || i_data_hi_we) |=> o_slave_ready_n)
        else $error("ready not released by upper access");
    master_drive_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ##1 o_shift_clk_oe == $past(master))
        else $error("clock drive wrong for mode");
    slave_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !o_busy && !i_transfer_trigger |=> $stable(r_q.cnt))
        else $error("counter moved while halted");
    trig_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !o_transfer_trigger)
        else $error("trigger read not zero");

    // Ready handshake steps, slave side
    sequence trig_slave_s;
        i_transfer_trigger && !o_busy && !master && READY_USED && !i_data_hi_we && !i_data_hi_rd;
    endsequence
    sequence ready_wait_s;
        o_busy && !o_slave_ready_n;
    endsequence
    sequence first_fall_s;
        sh_fall;
    endsequence

    serial_out_pin_on_fall_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ##1 $changed(o_serial_out_pin) |-> $past(sh_fall))
        else $error("serial output moved off a falling edge");

    shift_on_cap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_busy && !cap && !i_data_lo_we && !i_data_hi_we |=> $stable(r_q.sr))
        else $error("shift register moved off the capture edge");

    ready_fall_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        trig_slave_s |=> !o_slave_ready_n)
        else $error("ready did not fall on trigger");

    ready_rise_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ready_wait_s ##0 first_fall_s |=> o_slave_ready_n)
        else $error("ready did not rise on first low clock");

    ready_master_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_shift_clk_oe |-> o_slave_ready_n)
        else $error("ready asserted in master mode");

    cfg_held_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_busy |=> $stable(o_clock_select) && $stable(o_sample_edge_select))
        else $error("configuration changed while busy");

    cnt_bound_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        r_q.cnt <= `CSSP_CNT_W'(NB))
        else $error("shift clock count past eight");

    irq_enabled_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_transfer_done_flag && !i_flag_clear && i_transfer_done_mask |=> o_irq)
        else $error("irq missing with flag and enable");

    flag_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_flag_clear && !done |=> !o_transfer_done_flag)
        else $error("flag not cleared");

    clk_rate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_busy && master && r_q.div != half - `CSSP_DIV_W'(1) |=> $stable(o_shift_clk_out))
        else $error("shift clock toggled off its rate");

    slave_clk_still_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !o_shift_clk_oe && !master |-> o_shift_clk_out)
        else $error("internal clock moved in slave mode");
endmodule // cssp_port

/* hdl/cssp_params.svh */
// Constants for the clocked serial shift port
`ifndef CSSP_PARAMS_SVH
`define CSSP_PARAMS_SVH
`define CSSP_BITS        8
`define CSSP_CNT_W       4
`define CSSP_CS_W        2
`define CSSP_CS_SLAVE    2'h0
`define CSSP_CS_DIV4     2'h1
`define CSSP_CS_DIV2     2'h2
`define CSSP_CS_DIV1     2'h3
`define CSSP_CS_RESET    2'h0
`define CSSP_SEN_RESET   1'h0
`define CSSP_DIV_W       3
`define CSSP_DIV1_HALF   3'h1
`define CSSP_DIV2_HALF   3'h2
`define CSSP_DIV4_HALF   3'h4
`endif

/* hdl/cssp_pkg.sv */
// Types for the clocked serial shift port
package cssp_pkg;
    typedef enum logic [1:0] {
        CSSP_IDLE,
        CSSP_RUN
    } cssp_state_t;
endpackage

/* hdl/cssp_edge.sv */
// Edge detector for the external shift clock input
`timescale 1ns/1ps
`include "cssp_params.svh"
module cssp_edge (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    // Sampled level
    input  wire logic i_level,
    // Edge pulses
    output logic      o_rise,
    output logic      o_fall
);
    logic prev_q;

    // Level history, idle high
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_q <= 1'h1;
        end else begin
            prev_q <= i_level;
        end
    end

    // Edge decode
    assign o_rise = i_level & ~prev_q;
    assign o_fall = ~i_level & prev_q;
endmodule // cssp_edge

/* tb/cssp_far_dev.sv */
// Far-side serial device model: external clock source and byte exchange
`timescale 1ns/1ps
module cssp_far_dev (
    // Bench control
    input  wire logic       i_ref_clk,
    input  wire logic       i_arm,
    input  wire logic       i_go,
    input  wire logic       i_rise_launch,
    input  wire logic [3:0] i_nclk,
    input  wire logic [7:0] i_tx,
    // Serial wires
    input  wire logic       i_wire_clk,
    input  wire logic       i_serial_out_pin,
    output logic            o_sclk,
    output logic            o_sin,
    output logic [7:0]      o_rx
);
    int idx;
    int n_rise;
    // Idle: clock high on its pull-up
    initial begin
        o_sclk = 1'b1;
        o_sin = 1'b1;
        o_rx = 8'h00;
    end
    // Frame start; early launch presents bit 0 at once
    always @(posedge i_arm) begin
        n_rise = 0;
        idx = i_rise_launch ? 1 : 0;
        if (i_rise_launch) o_sin = i_tx[0];
    end
    // Launch on the falling clock edge
    always @(negedge i_wire_clk) begin
        if (!i_rise_launch && idx < 8) begin
            o_sin = i_tx[idx];
            idx++;
        end
    end
    // Capture LSB first; line inverted once hold time is over
    always @(posedge i_wire_clk) begin
        if (n_rise < 8) begin
            o_rx = {i_serial_out_pin, o_rx[7:1]};
            n_rise++;
            if (n_rise == 8) begin
                repeat (3) @(negedge i_ref_clk);
                o_sin = ~o_sin;
            end else if (i_rise_launch) begin
                o_sin = i_tx[idx];
                idx++;
            end
        end
    end
    // clocks only once told, after the trigger
    always @(posedge i_go) begin
        repeat (i_nclk) begin
            repeat (4) @(negedge i_ref_clk);
            o_sclk = 1'b0;
            repeat (4) @(negedge i_ref_clk);
            o_sclk = 1'b1;
        end
    end
endmodule // cssp_far_dev

/* tb/cssp_port_tb.sv */
// Self-checking bench for the clocked serial shift port
`timescale 1ns/1ps
module cssp_port_tb;
    logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_clock_select_lo = 1'b0, i_clock_select_hi = 1'b0;
    logic i_cfg_we = 1'b0, i_sample_edge_select = 1'b0, i_transfer_done_mask = 1'b0;
    logic i_transfer_trigger = 1'b0, i_data_lo_we = 1'b0, i_data_hi_we = 1'b0;
    logic i_data_hi_rd = 1'b0, i_flag_clear = 1'b0;
    logic [3:0] i_wdata = 4'h0;
    logic i_serial_in_pin, i_shift_clk_in, o_shift_clk_out, o_shift_clk_oe, o_serial_out_pin;
    logic o_slave_ready_n, o_sample_edge_select, o_transfer_trigger, o_busy, o_transfer_done_flag, o_irq;
    logic [3:0] o_shift_data_lower, o_shift_data_upper;
    logic [1:0] o_clock_select;
    logic arm = 1'b0, go = 1'b0, rise_l = 1'b0, far_sclk, prev = 1'b1;
    logic [3:0] far_n = 4'h8;
    logic [7:0] far_tx = 8'h00, far_rx;
    int miscompares = 0, n_tests = 0, cyc = 0, nfall = 0, first_c = 0, last_c = 0, hung = 0;

    // Shared shift clock line: the enabled driver owns it
    assign i_shift_clk_in = o_shift_clk_oe ? o_shift_clk_out : far_sclk;
    // reference clock never switched during a transfer
    always #12.5 i_ref_clk = ~i_ref_clk;

    cssp_port i_cssp_port (.*);
    cssp_far_dev i_cssp_far_dev (
        .i_ref_clk(i_ref_clk), .i_arm(arm), .i_go(go), .i_rise_launch(rise_l), .i_nclk(far_n),
        .i_tx(far_tx), .i_wire_clk(i_shift_clk_in), .i_serial_out_pin(o_serial_out_pin), .o_sclk(far_sclk),
        .o_sin(i_serial_in_pin), .o_rx(far_rx));

    // Falling edges of the driven shift clock and their spacing
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        prev <= o_shift_clk_out;
        if (prev && !o_shift_clk_out) begin
            if (nfall == 0) first_c <= cyc;
            last_c <= cyc;
            nfall <= nfall + 1;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // One byte exchange: load, configure, trigger, wait, check
    task automatic xfer(input logic [7:0] d, input logic [1:0] cs, input logic sample_edge_select, input logic mask,
                        input logic [7:0] tx, input logic [3:0] n, input logic rd);
        int w;
        if (hung) return;
        // data halves written only while halted
        @(posedge i_ref_clk);
        i_wdata <= d[3:0];
        i_data_lo_we <= 1'b1;
        @(posedge i_ref_clk);
        i_data_lo_we <= 1'b0;
        i_data_hi_we <= 1'b1;
        i_wdata <= d[7:4];
        {i_clock_select_hi, i_clock_select_lo} <= cs;
        i_sample_edge_select <= sample_edge_select;
        i_transfer_done_mask <= mask;
        i_cfg_we <= 1'b1;
        @(posedge i_ref_clk);
        i_data_hi_we <= 1'b0;
        i_cfg_we <= 1'b0;
        i_transfer_trigger <= 1'b1;
        far_tx <= tx;
        rise_l <= sample_edge_select;
        far_n <= n;
        arm <= 1'b1;
        @(posedge i_ref_clk);
        i_transfer_trigger <= 1'b0;
        arm <= 1'b0;
        nfall = 0;
        @(negedge i_ref_clk);
        chk(o_busy, 1'b1);
        chk(o_clock_select, cs);
        chk(o_sample_edge_select, sample_edge_select);
        chk(o_transfer_trigger, 1'b0);
        chk(o_shift_clk_oe, cs != 2'h0);
        chk(o_slave_ready_n, cs != 2'h0);
        if (rd) begin
            @(posedge i_ref_clk);
            i_data_hi_rd <= 1'b1;
            @(posedge i_ref_clk);
            i_data_hi_rd <= 1'b0;
            @(negedge i_ref_clk);
            chk(o_slave_ready_n, 1'b1);
        end
        if (cs == 2'h0) begin
            @(posedge i_ref_clk);
            go <= 1'b1;
            @(posedge i_ref_clk);
            go <= 1'b0;
        end
        for (w = 0; w < 400 && o_busy !== 1'b0; w++) @(negedge i_ref_clk);
        if (w == 400) begin
            miscompares++;
            hung = 1;
            return;
        end
        repeat (16) @(negedge i_ref_clk);
        chk(o_busy, 1'b0);
        chk(o_transfer_done_flag, 1'b1);
        chk(o_irq, mask);
        chk({o_shift_data_upper, o_shift_data_lower}, tx);
        chk(far_rx, d);
        chk(o_shift_clk_out, 1'b1);
        chk(o_slave_ready_n, 1'b1);
        if (cs != 2'h0) begin
            chk(nfall[7:0], 8'h08);
            chk(8'(last_c - first_c), 8'(14 << (3 - cs)));
        end
        @(posedge i_ref_clk);
        i_flag_clear <= 1'b1;
        @(posedge i_ref_clk);
        i_flag_clear <= 1'b0;
        @(negedge i_ref_clk);
        chk(o_transfer_done_flag, 1'b0);
        chk(o_irq, 1'b0);
    endtask

    // Reset values, then master rates and slave cases
    initial begin
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk(o_clock_select, 2'h0);
        chk(o_sample_edge_select, 1'b0);
        chk(o_shift_clk_out, 1'b1);
        chk(o_shift_clk_oe, 1'b0);
        chk(o_slave_ready_n, 1'b1);
        chk(o_transfer_done_flag, 1'b0);
        @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        xfer(8'h3C, 2'h3, 1'b0, 1'b1, 8'hA6, 4'h8, 1'b0);
        xfer(8'h5A, 2'h2, 1'b0, 1'b0, 8'h81, 4'h8, 1'b0);
        xfer(8'hC3, 2'h1, 1'b0, 1'b1, 8'h1E, 4'h8, 1'b0);
        xfer(8'h96, 2'h0, 1'b0, 1'b1, 8'h6D, 4'h9, 1'b0);
        xfer(8'h2B, 2'h0, 1'b1, 1'b0, 8'hD4, 4'h8, 1'b1);
        stop_test();
    end
endmodule // cssp_port_tb
